//--- pulse_timer_block.sv
// Retriggerable on-pulse timer with a disabled mode and readable elapsed time.
// Assumes run_in is asynchronous; configuration ports are static or mclk-synchronous.
`timescale 1ns/1ps
`include "pulse_timer_consts.svh"
module pulse_timer_block
  import pulse_timer_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     run_in,
  input  wire logic                     func_pulse,
  input  wire logic                     run_active_high,
  input  wire logic                     out_active_high,
  input  wire logic [`TIME_WIDTH-1:0]   duration,
  output logic                          timer_out,
  output logic [`TIME_WIDTH-1:0]        elapsed
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic run_s1_q;
  logic run_s2_q;
  logic run_prev_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic rst_n = rst_s2_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_s1_q   <= 1'b0;
      run_s2_q   <= 1'b0;
      run_prev_q <= 1'b0;
    end
    else
    begin
      run_s1_q   <= run_in;
      run_s2_q   <= run_s1_q;
      run_prev_q <= run_s2_q;
    end
  end

  // Three edges after release are needed before the synchroniser and the previous
  // sample both hold the pin level. Until then a difference between them is only the
  // flops filling from their reset value, so it must not count as a run edge.
  logic [1:0] warm_q;
  logic [1:0] warm_d;
  logic       warm;

  always_comb
  begin
    warm_d = warm_q;
    if (warm_q != 2'h3)
      warm_d = warm_q + 2'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      warm_q <= 2'h0;
    else
      warm_q <= warm_d;
  end

  assign warm = (warm_q == 2'h3);

  // A pin that idles high would otherwise give a false rising edge right after reset.
  logic trig;
  always_comb
  begin
    if (run_active_high)
      trig = warm & run_s2_q & ~run_prev_q;
    else
      trig = warm & ~run_s2_q & run_prev_q;
  end

  // Duration above the range is clamped so the pulse length stays bounded.
  logic [`TIME_WIDTH-1:0] dur_lim;
  assign dur_lim = (duration > `TIME_MAX) ? `TIME_MAX : duration;

  logic [31:0]            tick_cnt_q;
  logic [31:0]            tick_cnt_d;
  logic                   tick;
  state_t                 state_q;
  state_t                 state_d;
  logic [`TIME_WIDTH-1:0] elapsed_q;
  logic [`TIME_WIDTH-1:0] elapsed_d;
  logic                   out_q;
  logic                   out_d;

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // The tick counter free-runs rather than restarting on a trigger, so the first
  // count of a pulse lands anywhere within one tick; a pulse may be up to one tick short.
  always_comb
  begin
    tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  always_comb
  begin
    state_d    = state_q;
    elapsed_d  = elapsed_q;
    case (state_q)
      ST_IDLE:
      begin
        elapsed_d = '0;
        if (func_pulse && trig)
        begin
          if (dur_lim != '0)
            state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!func_pulse)
        begin
          state_d   = ST_IDLE;
          elapsed_d = '0;
        end
        else if (trig)
          elapsed_d = '0;
        else if (elapsed_q >= dur_lim)
        begin
          state_d   = ST_IDLE;
          elapsed_d = '0;
        end
        else if (tick)
        begin
          // Run input is not looked at here, so an early release keeps the pulse.
          elapsed_d = elapsed_q + `TIME_WIDTH'(1);
          if (elapsed_d >= dur_lim)
          begin
            state_d   = ST_IDLE;
            elapsed_d = '0;
          end
        end
      end
      default:
      begin
        state_d   = ST_IDLE;
        elapsed_d = '0;
      end
    endcase
    // Output takes the active level while running and its opposite otherwise; reset loads 0 at either polarity.
    out_d = (state_d == ST_RUN) ? out_active_high : ~out_active_high;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= ST_IDLE;
      elapsed_q  <= '0;
      out_q      <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      elapsed_q  <= elapsed_d;
      out_q      <= out_d;
    end
  end

  assign timer_out = out_q;
  assign elapsed   = elapsed_q;

endmodule // pulse_timer_block

//--- pulse_timer_consts.svh
// Constants for the pulse timer: tick base, widths and limits.
// Assumes inclusion by bare name from the package and design file.
`ifndef PULSE_TIMER_CONSTS_SVH
`define PULSE_TIMER_CONSTS_SVH
`define CLK_FREQ_HZ        50000000
`define TICK_PERIOD_US     1000
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)
`define TIME_WIDTH         27
`define TIME_MAX           27'h5f5dd18
`endif

//--- pulse_timer_pkg.sv
// Types shared by the pulse timer.
// Assumes the constants header sits in the same folder.
`include "pulse_timer_consts.svh"
package pulse_timer_pkg;
  typedef enum logic [0:0] {
    FUNC_OFF,
    FUNC_PULSE
  } func_t;
  typedef enum {
    ST_IDLE,
    ST_RUN
  } state_t;
endpackage

//--- pulse_timer_properties.sv
// Port checker for the pulse timer.
// Assumes a bind onto pulse_timer_block with config held still while a pulse runs.
`timescale 1ns/1ps
`include "pulse_timer_consts.svh"
module pulse_timer_properties (
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire logic                   run_in,
  input wire logic                   func_pulse,
  input wire logic                   run_active_high,
  input wire logic                   out_active_high,
  input wire logic [`TIME_WIDTH-1:0] duration,
  input wire logic                   timer_out,
  input wire logic [`TIME_WIDTH-1:0] elapsed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // The run input is seen through a synchroniser, so starts land a few clocks late.
  sequence s_trig;
    func_pulse && duration != 0 && (run_active_high ? $rose(run_in) : $fell(run_in));
  endsequence
  a_off_level: assert property (!func_pulse && !$past(func_pulse) && $stable(out_active_high)
    && $past(resetn, 4) |-> timer_out == !out_active_high) else $error("idle level");
  a_trig_start: assert property (s_trig |-> ##[1:5] timer_out == out_active_high)
    else $error("no start");
  a_retrig_restart: assert property (s_trig ##0 elapsed != 0 |-> ##[1:5] elapsed == 0)
    else $error("no restart");
  a_run_active: assert property (elapsed != 0 |-> timer_out == out_active_high) else $error("idle count");
  a_count_step: assert property ($changed(elapsed) |-> elapsed == 0 || elapsed == $past(elapsed) + 1)
    else $error("bad step");
  a_below_dur: assert property (elapsed != 0 |-> elapsed < duration) else $error("overrun");
  a_off_clear: assert property ($fell(func_pulse) |=> elapsed == 0) else $error("not cleared");
  a_reset_zero: assert property ($rose(resetn) |-> elapsed == 0 && !timer_out) else $error("reset value");
endmodule // pulse_timer_properties
bind pulse_timer_block pulse_timer_properties i_chk (.mclk, .resetn, .run_in, .func_pulse, .run_active_high,
  .out_active_high, .duration, .timer_out, .elapsed);

//--- run_source.sv
// Upstream logic model that drives the timer's run input.
// Assumes the bench sets the wanted level just after a rising edge.
`timescale 1ns/1ps
module run_source (
  input  wire logic mclk,
  input  wire logic lvl,
  output logic      run_q
);
  // Registered like real upstream logic, so each edge arrives one clock late.
  initial run_q = 1'b0;
  always @(posedge mclk) run_q <= lvl;
endmodule // run_source

//--- pulse_timer_block_test.sv
// Bench for the pulse timer: idle level, pulse lengths, polarity and retrigger.
// Assumes the run source model and a tick shortened to 4 clocks.
`timescale 1ns/1ps
`include "pulse_timer_consts.svh"
module pulse_timer_block_test;
  logic mclk = 0, resetn = 0, lvl = 0, fp = 0, rah = 1, oah = 1, run_in, timer_out;
  logic [`TIME_WIDTH-1:0] dur = 0, elapsed;
  int n_errors = 0, compares = 0;
  initial forever #10 mclk = ~mclk;
  run_source i_src (.mclk(mclk), .lvl(lvl), .run_q(run_in));
  pulse_timer_block #(.TICK_CYCLES(4)) i_dut (.mclk(mclk), .resetn(resetn), .run_in(run_in), .func_pulse(fp),
    .run_active_high(rah), .out_active_high(oah), .duration(dur), .timer_out(timer_out), .elapsed(elapsed));
  task check(input logic [`TIME_WIDTH-1:0] seen, want);
    compares++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Run toggles while off must not move the output; the pulse is counted over a fixed window.
  task shot(input logic r, o, input int d, rt, lo, hi);
    int n;
    n = 0;
    @(posedge mclk);
    fp <= 0;
    rah <= r;
    oah <= o;
    dur <= d;
    lvl <= !r;
    repeat (8)
    begin
      @(posedge mclk);
      lvl <= ~lvl;
    end
    repeat (6) @(posedge mclk);
    check(timer_out, !o);
    fp <= 1;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 60; i++)
    begin
      if (i == 0 || i == rt) lvl <= r;
      if (i == 2) lvl <= !r;
      @(negedge mclk);
      n += (timer_out === o);
      @(posedge mclk);
    end
    check(n >= lo && n <= hi, 1);
    check(elapsed, 0);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1;
    shot(1, 1, 5, 99, 16, 21);
    shot(0, 0, 5, 10, 26, 31);
    shot(1, 0, 0, 99, 0, 0);
    shot(0, 1, 5, 99, 16, 21);
    tally_and_finish;
  end
endmodule // pulse_timer_block_test
